// *** verif/adc_conversion_control_bench.sv ***
module adc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;

  logic sys_clk_i;
  logic rst_i;
  bus_req_type bus_i;
  logic [DATA_W-1:0] rdata_o;
  logic [RES_W-1:0] conv_data_i;
  logic conv_clk_en_o;
  logic converter_reset_o;
  logic converter_power_off_o;
  logic [PIN_W-1:0] analog_pin_enable_o;
  logic irq_o;
  int n_mismatch;
  int n_tests;

  adc_conversion_control dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .conv_data_i(conv_data_i),
    .conv_clk_en_o(conv_clk_en_o),
    .converter_reset_o(converter_reset_o),
    .converter_power_off_o(converter_power_off_o),
    .analog_pin_enable_o(analog_pin_enable_o),
    .irq_o(irq_o)
  );

  // ***************************************************
  // clock and watchdog
  // ***************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // nine full conversions at most 16*64 cycles each, plus slack
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    end_of_test();
  end

  // ***************************************************
  // bus tasks
  // ***************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask

  // one idle edge before each strobe keeps every signal single-driven
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    #1;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    q = rdata_o;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e,
                        input string what);
    logic [7:0] q;
    rd_reg(a, q);
    check(q, e, what);
  endtask

  // counts ticks over n cycles, flags any reset level other than rst_exp or any interrupt
  task automatic idle_watch(input int n, input logic rst_exp);
    int ticks;
    ticks = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      if (conv_clk_en_o !== 1'b0) ticks++;
      check({7'h0, converter_reset_o}, {7'h0, rst_exp}, "reset level");
      check({7'h0, irq_o}, 8'h00, "irq idle");
    end
    check(8'(ticks), 8'h00, "ticks while idle");
  endtask

  // ***************************************************
  // one timed conversion per divider code
  // ***************************************************
  task automatic run_conv(input logic [SEL_W-1:0] sel);
    int d;
    int i;
    int ticks;
    int last;
    int bad_gap;
    d = (sel == 3'h7) ? 64 : (1 << sel);
    ticks = 0;
    last = 0;
    bad_gap = 0;
    i = 0;
    conv_data_i <= {sel, 9'h1a5};
    wr_reg(OFF_CTRL1, {5'h00, sel});
    wr_reg(OFF_CTRL0, 8'h00);
    wr_reg(OFF_CTRL0, 8'h80);
    check({7'h0, converter_reset_o}, 8'h01, "hold reset");
    rd_chk(OFF_CTRL0, 8'hc0, "busy in hold");
    wr_reg(OFF_CTRL0, 8'h00);
    while (i < 16 * d + 8 && irq_o !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      i++;
      if (conv_clk_en_o === 1'b1) begin
        if (ticks > 0 && i - last != d) bad_gap++;
        ticks++;
        last = i;
      end
    end
    check({7'h0, irq_o}, 8'h01, "irq raised");
    check(8'(ticks), 8'd16, "tick count");
    check(8'(bad_gap), 8'h00, "tick spacing");
    check({7'h0, 1'(i >= 16 * d && i <= 16 * d + 3)}, 8'h01,
          "conversion length");
    rd_chk(OFF_CTRL0, 8'h00, "busy cleared");
    rd_chk(OFF_IRQ_STAT, 8'h01, "done status");
    rd_chk(OFF_RES_LO, 8'ha5, "result low");
    rd_chk(OFF_RES_HI, {4'h0, sel, 1'b1}, "result high");
    wr_reg(OFF_IRQ_STAT, 8'h01);
    check({7'h0, irq_o}, 8'h00, "irq after clear");
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    logic [7:0] q;
    int k;
    n_mismatch = 0;
    n_tests = 0;
    rst_i = 1'b1;
    bus_i = '0;
    conv_data_i = 12'h000;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    check({4'h0, analog_pin_enable_o}, 8'h0f, "pin reset");
    check({7'h0, converter_power_off_o}, 8'h01, "power reset");
    rd_chk(OFF_PIN_EN, 8'h0f, "pin reg reset");
    rd_chk(OFF_CTRL0, 8'h20, "ctrl0 reset");
    rd_chk(OFF_CTRL1, 8'h00, "ctrl1 reset");
    wr_reg(4'hf, 8'hff);
    rd_chk(4'hf, 8'h00, "unmapped read");
    wr_reg(OFF_PIN_EN, 8'hfa);
    check({4'h0, analog_pin_enable_o}, 8'h0a, "pin routing");
    rd_chk(OFF_PIN_EN, 8'h0a, "pin upper zero");
    wr_reg(OFF_PIN_EN, 8'h05);
    check({4'h0, analog_pin_enable_o}, 8'h05, "pin routing");

    // start held high: no conversion while the bit stays up
    wr_reg(OFF_IRQ_MASK, 8'h01);
    wr_reg(OFF_CTRL0, 8'h00);
    wr_reg(OFF_CTRL0, 8'h80);
    idle_watch(100, 1'b1);
    rd_chk(OFF_CTRL0, 8'hc0, "busy while held");

    for (k = 0; k < 8; k++) begin
      run_conv(SEL_W'(k));
    end

    // masked: only polling, of busy or of the done status, can see the end
    // code 6 gives 640 ns at 100 MHz, inside the accurate range
    wr_reg(OFF_IRQ_MASK, 8'h00);
    wr_reg(OFF_CTRL1, 8'h06);
    wr_reg(OFF_CTRL0, 8'h80);
    wr_reg(OFF_CTRL0, 8'h00);
    rd_chk(OFF_CTRL0, 8'h40, "busy after fall");
    k = 0;
    q = 8'h40;
    while (k < 600 && q[BUSY_BIT] !== 1'b0) begin
      rd_reg(OFF_CTRL0, q);
      check({7'h0, irq_o}, 8'h00, "masked irq");
      k++;
    end
    check(q, 8'h00, "poll ends");
    rd_chk(OFF_IRQ_STAT, 8'h01, "masked status");
    wr_reg(OFF_IRQ_STAT, 8'h01);
    rd_chk(OFF_IRQ_STAT, 8'h00, "status cleared");

    // power off mid-conversion aborts, and blocks a new start
    wr_reg(OFF_IRQ_MASK, 8'h01);
    wr_reg(OFF_CTRL1, 8'h03);
    wr_reg(OFF_CTRL0, 8'h80);
    wr_reg(OFF_CTRL0, 8'h00);
    repeat (20) @(posedge sys_clk_i);
    wr_reg(OFF_CTRL0, 8'h20);
    check({7'h0, converter_power_off_o}, 8'h01, "power off");
    idle_watch(150, 1'b0);
    rd_chk(OFF_CTRL0, 8'h20, "abort busy");
    rd_chk(OFF_IRQ_STAT, 8'h00, "abort status");
    wr_reg(OFF_CTRL0, 8'ha0);
    wr_reg(OFF_CTRL0, 8'h20);
    idle_watch(150, 1'b0);
    rd_chk(OFF_IRQ_STAT, 8'h00, "no start powered off");
    end_of_test();
  end

  // ***************************************************
  // verdict
  // ***************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
endmodule // adc_conversion_control_bench

// *** verilog/adc_conversion_control.sv ***
// Overview of operation
// RL1: three-bit select divides sys clock 1..64
// RL2: conversion clock comes only from sys clock
// RL3: software keeps clock period 0.5 to 10 us
// RL4: pin enable bits route pins to channels
// RL5: upper four pin enable bits read zero
// RL6: conversion starts after full start pulse
// RL7: start held high resets converter, busy set
// RL8: busy clears itself when conversion ends
// RL9: end of conversion always sets request flag
// RL10: interrupt output only when enable set
// RL11: software may poll busy when interrupt off
// RL12: conversion lasts sixteen conversion clock periods
// RL13: power off bit shuts converter down
// RL14: software clears start before the pulse
// RL15: result readable as low and high byte
// RL16: busy stays high from start fall to end
module adc_conversion_control (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire adc_ctrl_pkg::bus_req_type bus_i,
  output logic [adc_ctrl_pkg::DATA_W-1:0] rdata_o,
  input wire logic [adc_ctrl_pkg::RES_W-1:0] conv_data_i,
  output logic conv_clk_en_o,
  output logic converter_reset_o,
  output logic converter_power_off_o,
  output logic [adc_ctrl_pkg::PIN_W-1:0] analog_pin_enable_o,
  output logic irq_o
);
  import adc_ctrl_pkg::*;

  // ***************************************************
  // state
  // ***************************************************
  conv_state_type state;
  conv_state_type next_state;
  logic start;
  logic next_start;
  logic converter_power_off;
  logic next_power_off;
  logic [SEL_W-1:0] conv_clock_divider_select;
  logic [SEL_W-1:0] next_div_sel;
  logic [PIN_W-1:0] analog_input_pin_enable;
  logic [PIN_W-1:0] next_pin_en;
  logic irq_status;
  logic next_irq_status;
  logic irq_mask;
  logic next_irq_mask;
  logic [TICK_CNT_W-1:0] tick_cnt;
  logic [TICK_CNT_W-1:0] next_tick_cnt;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] next_result;
  logic [DATA_W-1:0] next_rdata;
  logic conversion_busy_flag;
  logic start_rise;
  logic conv_done;
  logic div_clear;
  logic tick;

  // ***************************************************
  // conversion clock
  // ***************************************************
  // divider held cleared while converter is in reset, so the
  // sixteen periods are counted from the falling start edge
  assign div_clear = (state != ST_CONV);

  conv_clock_divider #(
    .CNT_W(DIV_CNT_W)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(div_clear),
    .sel_i(conv_clock_divider_select),
    .tick_o(tick)
  );

  assign conversion_busy_flag = (state != ST_IDLE);

  // ***************************************************
  // next values
  // ***************************************************
  always_comb begin
    next_start = start;
    next_power_off = converter_power_off;
    next_div_sel = conv_clock_divider_select;
    next_pin_en = analog_input_pin_enable;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_result = result;
    next_rdata = '0;
    conv_done = 1'b0;

    // register writes
    if (bus_i.wr) begin
      if (bus_i.addr == OFF_CTRL0) begin
        next_start = bus_i.wdata[START_BIT];
        next_power_off = bus_i.wdata[PWR_OFF_BIT];
      end else if (bus_i.addr == OFF_CTRL1) begin
        next_div_sel = bus_i.wdata[SEL_W-1:0]; // [RL1]
      end else if (bus_i.addr == OFF_PIN_EN) begin
        next_pin_en = bus_i.wdata[PIN_W-1:0]; // [RL4]
      end else if (bus_i.addr == OFF_IRQ_STAT) begin
        if (bus_i.wdata[DONE_BIT]) begin
          next_irq_status = 1'b0;
        end
      end else if (bus_i.addr == OFF_IRQ_MASK) begin
        next_irq_mask = bus_i.wdata[DONE_BIT];
      end
    end

    start_rise = next_start && !start;

    // conversion sequence
    case (state)
      ST_IDLE: begin
        if (start_rise) begin
          next_state = ST_HOLD; // [RL7]
        end
      end
      ST_HOLD: begin
        // only the falling half of the pulse starts work
        if (!next_start) begin
          if (next_power_off) begin
            next_state = ST_IDLE; // [RL13]
          end else begin
            next_state = ST_CONV; // [RL6] [RL16]
            next_tick_cnt = '0;
          end
        end
      end
      ST_CONV: begin
        // a fresh start edge wins so busy and reset follow it even
        // while powering down; the release then aborts from hold
        if (start_rise) begin
          next_state = ST_HOLD; // [RL7]
        end else if (next_power_off) begin
          // powering down abandons the conversion, no request
          next_state = ST_IDLE; // [RL13]
        end else if (tick) begin
          if (tick_cnt == CONV_LAST) begin
            next_state = ST_IDLE; // [RL8] [RL12]
            conv_done = 1'b1;
          end else begin
            next_tick_cnt = tick_cnt + TICK_CNT_W'(1);
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    if (conv_done) begin
      next_result = conv_data_i; // [RL15]
      // set beats a same-cycle write-one clear
      next_irq_status = 1'b1; // [RL9]
    end

    // register reads
    if (bus_i.rd) begin
      if (bus_i.addr == OFF_CTRL0) begin
        next_rdata[START_BIT] = start;
        next_rdata[BUSY_BIT] = conversion_busy_flag; // [RL8]
        next_rdata[PWR_OFF_BIT] = converter_power_off;
      end else if (bus_i.addr == OFF_CTRL1) begin
        next_rdata[SEL_W-1:0] = conv_clock_divider_select;
      end else if (bus_i.addr == OFF_PIN_EN) begin
        // bits 7..4 stay zero
        next_rdata[PIN_W-1:0] = analog_input_pin_enable; // [RL5]
      end else if (bus_i.addr == OFF_RES_LO) begin
        next_rdata = result[RES_LO_W-1:0]; // [RL15]
      end else if (bus_i.addr == OFF_RES_HI) begin
        next_rdata[RES_W-RES_LO_W-1:0] =
          result[RES_W-1:RES_LO_W]; // [RL15]
      end else if (bus_i.addr == OFF_IRQ_STAT) begin
        next_rdata[DONE_BIT] = irq_status;
      end else if (bus_i.addr == OFF_IRQ_MASK) begin
        next_rdata[DONE_BIT] = irq_mask;
      end
    end
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      start <= 1'b0;
      converter_power_off <= PWR_OFF_RST;
      conv_clock_divider_select <= DIV_SEL_RST;
      analog_input_pin_enable <= PIN_EN_RST;
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
      tick_cnt <= '0;
      result <= RESULT_RST;
      rdata_o <= '0;
      conv_clk_en_o <= 1'b0;
      converter_reset_o <= 1'b0;
      converter_power_off_o <= PWR_OFF_RST;
      analog_pin_enable_o <= PIN_EN_RST;
      irq_o <= 1'b0;
    end else begin
      state <= next_state;
      start <= next_start;
      converter_power_off <= next_power_off;
      conv_clock_divider_select <= next_div_sel;
      analog_input_pin_enable <= next_pin_en;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      tick_cnt <= next_tick_cnt;
      result <= next_result;
      rdata_o <= next_rdata;
      conv_clk_en_o <= tick && (state == ST_CONV); // [RL2]
      converter_reset_o <= (next_state == ST_HOLD); // [RL7]
      converter_power_off_o <= next_power_off; // [RL13]
      analog_pin_enable_o <= next_pin_en; // [RL4]
      irq_o <= next_irq_status && next_irq_mask; // [RL10]
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic [11:0] conv_cycles;
  logic [6:0] div_ratio;
  logic sel_moved;
  // a divider rewrite mid-conversion makes the length unpredictable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || state != ST_CONV) begin
      conv_cycles <= '0;
      sel_moved <= 1'b0;
    end else begin
      conv_cycles <= conv_cycles + 12'h001;
      sel_moved <= sel_moved || (next_div_sel != conv_clock_divider_select);
    end
  end
  always_comb begin
    div_ratio = (conv_clock_divider_select == DIV_SEL_UNDEF) ?
      7'h40 : 7'(7'h01 << conv_clock_divider_select);
  end

  sequence start_pulse_s;
    (state == ST_HOLD) ##1 (state == ST_CONV);
  endsequence

  sequence conv_end_s;
    (state == ST_CONV) ##1 (state == ST_IDLE) && !converter_power_off;
  endsequence

  start_pulse_a: assert property ( // [RL6]
    start_pulse_s |-> $fell(start) && conversion_busy_flag)
    else $error("conversion began without falling start");

  busy_hold_a: assert property ( // [RL7]
    $rose(start) |-> state == ST_HOLD && converter_reset_o
      && conversion_busy_flag)
    else $error("start high did not reset converter");

  busy_clear_a: assert property ( // [RL8]
    conv_end_s |-> !conversion_busy_flag && irq_status)
    else $error("busy did not clear at conversion end");

  conv_length_a: assert property ( // [RL12]
    conv_done && !sel_moved && $stable(conv_clock_divider_select)
      |-> conv_cycles == 12'(CONV_TICKS) * 12'(div_ratio))
    else $error("conversion length not sixteen periods");

  busy_span_a: assert property ( // [RL16]
    start_pulse_s |-> conversion_busy_flag [*2])
    else $error("busy dropped during conversion");

  done_flag_a: assert property ( // [RL9]
    conv_done |=> irq_status)
    else $error("end of conversion did not set request");

  irq_gate_a: assert property ( // [RL10]
    irq_o == (irq_status && irq_mask))
    else $error("interrupt output not gated by mask");

  pin_route_a: assert property ( // [RL4]
    bus_i.wr && bus_i.addr == OFF_PIN_EN
      |=> analog_pin_enable_o == $past(bus_i.wdata[PIN_W-1:0]))
    else $error("pin enable not routed");

  reserved_read_a: assert property ( // [RL5]
    bus_i.rd && bus_i.addr == OFF_PIN_EN |=> rdata_o[7:4] == 4'h0)
    else $error("reserved pin enable bits not zero");

  power_off_a: assert property ( // [RL13]
    converter_power_off |-> state != ST_CONV && converter_power_off_o)
    else $error("converter ran while powered off");

  result_cap_a: assert property ( // [RL15]
    conv_done |=> result == $past(conv_data_i))
    else $error("result not captured at end");

endmodule // adc_conversion_control

// *** verilog/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  // ***************************************************
  // register map (byte offsets on the plain port)
  // ***************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_PIN_EN = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_RES_LO = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_RES_HI = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h6;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int PWR_OFF_BIT = 5;
  localparam int DONE_BIT = 0;
  localparam int SEL_W = 3;
  localparam int PIN_W = 4;
  localparam int RES_W = 12;
  localparam int RES_LO_W = 8;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [PIN_W-1:0] PIN_EN_RST = 4'hf;
  localparam logic [SEL_W-1:0] DIV_SEL_RST = 3'h0;
  localparam logic PWR_OFF_RST = 1'h1;
  localparam logic [RES_W-1:0] RESULT_RST = 12'h000;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CONV_TICKS = 16;
  localparam int TICK_CNT_W = 4;
  localparam logic [TICK_CNT_W-1:0] CONV_LAST =
    TICK_CNT_W'(CONV_TICKS - 1);
  localparam logic [SEL_W-1:0] DIV_SEL_UNDEF = 3'h7;
  localparam logic [SEL_W-1:0] DIV_SEL_MAX = 3'h6;
  localparam int DIV_CNT_W = 6;

  // ***************************************************
  // carriers and states
  // ***************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_CONV = 3'b100
  } conv_state_type;

endpackage

// *** verilog/conv_clock_divider.sv ***
module conv_clock_divider #(
  parameter int CNT_W = 6
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic [adc_ctrl_pkg::SEL_W-1:0] sel_i,
  output logic tick_o
);
  import adc_ctrl_pkg::*;

  if (CNT_W < DIV_CNT_W) begin : g_chk
    $error("divider counter too narrow for divide by 64");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_tick;
  logic [SEL_W-1:0] sel_eff;
  logic [CNT_W-1:0] limit;

  always_comb begin
    // the undefined code runs as the slowest rate, never faster
    sel_eff = (sel_i == DIV_SEL_UNDEF) ? DIV_SEL_MAX : sel_i;
    limit = CNT_W'((64'(1) << sel_eff) - 64'(1));
    next_count = count;
    next_tick = 1'b0;
    if (clear_i) begin
      next_count = '0;
    end else if (count >= limit) begin
      next_count = '0;
      next_tick = 1'b1;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  // only source is sys_clk_i, undivided or divided [RL2]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= next_count; // [RL1]
      tick_o <= next_tick;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic [CNT_W:0] since;
  logic seen;
  logic [SEL_W-1:0] last_sel;
  // a select change voids the next spacing check
  always_ff @(posedge sys_clk_i) begin
    last_sel <= sel_i;
    if (rst_i || clear_i) begin
      since <= '0;
      seen <= 1'b0;
    end else if (tick_o) begin
      since <= (CNT_W+1)'(1);
      seen <= (sel_i == last_sel);
    end else begin
      since <= since + (CNT_W+1)'(1);
      if (sel_i != last_sel) begin
        seen <= 1'b0;
      end
    end
  end

  tick_spacing_a: assert property ( // [RL1]
    tick_o && seen && $stable(sel_i) && !clear_i
      |-> since == (CNT_W+1)'(limit) + (CNT_W+1)'(1))
    else $error("conversion clock tick spacing wrong");

endmodule // conv_clock_divider
